// ===== design/spi_seq_flags.sv
// buffer sequencer and per-buffer flag handling of a multi-buffered spi
`timescale 1ns/1ps

module spi_seq_flags (
    input wire logic clk,
    input wire logic reset_n,
    // transmit buffer loading by the host
    input wire logic tx_wr_valid,
    input wire logic [spi_seq_pkg::IDX_W-1:0] tx_wr_index,
    input wire spi_seq_pkg::tx_entry_t tx_wr_entry,
    // receive buffer reading by the host
    input wire logic host_rd_valid,
    input wire logic [spi_seq_pkg::IDX_W-1:0] host_rd_index,
    output logic [spi_seq_pkg::DATA_W-1:0] host_rd_data,
    // transfer group setup and triggers, group 0 has top priority
    input wire spi_seq_pkg::group_range_t group_range [spi_seq_pkg::NUM_GROUPS],
    input wire logic [spi_seq_pkg::NUM_GROUPS-1:0] group_trigger,
    // shift engine on the same clock
    output logic shift_start,
    output logic [spi_seq_pkg::DATA_W-1:0] shift_tx_data,
    input wire logic shift_done,
    input wire logic [spi_seq_pkg::DATA_W-1:0] shift_rx_data,
    // status
    output logic rx_overrun,
    output logic seq_busy,
    output logic [spi_seq_pkg::GRP_W-1:0] active_group,
    output logic [spi_seq_pkg::NUM_BUF-1:0] receive_slot_vacant_flag,
    output logic [spi_seq_pkg::NUM_BUF-1:0] transmit_slot_loaded_flag
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic is_suspend(input logic [spi_seq_pkg::MODE_W-1:0] mode);
        is_suspend = (mode == spi_seq_pkg::MODE_SUSPEND_A) ||
                     (mode == spi_seq_pkg::MODE_SUSPEND_B);
    endfunction

    // lowest pending index wins, i.e. highest priority
    function automatic logic [spi_seq_pkg::GRP_W-1:0] top_group(
        input logic [spi_seq_pkg::NUM_GROUPS-1:0] req);
        top_group = '0;
        for (int g = spi_seq_pkg::NUM_GROUPS - 1; g >= 0; g--) begin
            if (req[g]) begin
                top_group = spi_seq_pkg::GRP_W'(g);
            end
        end
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    spi_seq_pkg::tx_entry_t tx_mem [spi_seq_pkg::NUM_BUF];
    logic [spi_seq_pkg::DATA_W-1:0] rx_mem [spi_seq_pkg::NUM_BUF];
    spi_seq_pkg::seq_state_t state, next_state;
    logic [spi_seq_pkg::IDX_W-1:0] ptr, next_ptr;
    logic [spi_seq_pkg::GRP_W-1:0] next_active_group;
    logic [spi_seq_pkg::NUM_GROUPS-1:0] pending, next_pending;
    logic fetched_loaded, next_fetched_loaded;
    logic [spi_seq_pkg::MODE_W-1:0] fetched_mode, next_fetched_mode;
    logic [spi_seq_pkg::DATA_W-1:0] next_shift_tx_data, next_host_rd_data;
    logic next_shift_start, next_rx_overrun;
    logic [spi_seq_pkg::NUM_BUF-1:0] next_vacant, next_loaded;
    logic fetch_go, store_go, preempt, advance_done;
    logic [spi_seq_pkg::GRP_W-1:0] req_group;

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    assign req_group = top_group(pending);
    assign preempt = (state == spi_seq_pkg::SEQ_FETCH) && (pending != '0) &&
                     (req_group < active_group);
    assign store_go = (state == spi_seq_pkg::SEQ_SHIFT) && shift_done;
    assign advance_done = (ptr == group_range[active_group].last);

    // fetch, stall, transfer and store; pre-emption only between words
    always_comb begin
        next_state = state;
        next_ptr = ptr;
        next_active_group = active_group;
        next_pending = pending;
        next_fetched_loaded = fetched_loaded;
        next_fetched_mode = fetched_mode;
        next_shift_tx_data = shift_tx_data;
        next_shift_start = 1'b0;
        fetch_go = 1'b0;
        unique case (state)
            spi_seq_pkg::SEQ_IDLE: begin
                if (pending != '0) begin
                    next_active_group = req_group;
                    next_ptr = group_range[req_group].first;
                    next_pending[req_group] = 1'b0;
                    next_state = spi_seq_pkg::SEQ_FETCH;
                end
            end
            spi_seq_pkg::SEQ_FETCH: begin
                if (preempt) begin
                    // restart at the first buffer of the new group
                    next_active_group = req_group;
                    next_ptr = group_range[req_group].first;
                    next_pending[req_group] = 1'b0;
                end else begin
                    // flag and buffer are sampled in the same cycle
                    next_fetched_loaded = transmit_slot_loaded_flag[ptr];
                    next_fetched_mode = tx_mem[ptr].mode;
                    if (tx_mem[ptr].mode == spi_seq_pkg::MODE_DISABLED ||
                        (tx_mem[ptr].mode == spi_seq_pkg::MODE_SKIP_EMPTY &&
                         !transmit_slot_loaded_flag[ptr])) begin
                        next_state = advance_done ? spi_seq_pkg::SEQ_IDLE
                                                  : spi_seq_pkg::SEQ_FETCH;
                        next_ptr = advance_done ? ptr : ptr + 1'b1;
                    end else if (is_suspend(tx_mem[ptr].mode) &&
                                 !receive_slot_vacant_flag[ptr]) begin
                        next_state = spi_seq_pkg::SEQ_FETCH; // stall
                    end else begin
                        fetch_go = 1'b1;
                        next_shift_tx_data = tx_mem[ptr].data;
                        next_shift_start = 1'b1;
                        next_state = spi_seq_pkg::SEQ_SHIFT;
                    end
                end
            end
            spi_seq_pkg::SEQ_SHIFT: begin
                if (shift_done) begin
                    next_state = advance_done ? spi_seq_pkg::SEQ_IDLE
                                              : spi_seq_pkg::SEQ_FETCH;
                    next_ptr = advance_done ? ptr : ptr + 1'b1;
                end
            end
            default: begin
                next_state = spi_seq_pkg::SEQ_IDLE;
            end
        endcase
        // a trigger in the same cycle as its clear is kept
        next_pending = next_pending | group_trigger;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= spi_seq_pkg::SEQ_IDLE;
            ptr <= '0;
            active_group <= '0;
            pending <= '0;
            fetched_loaded <= 1'b0;
            fetched_mode <= spi_seq_pkg::MODE_DISABLED;
            shift_tx_data <= spi_seq_pkg::DATA_RESET;
            shift_start <= 1'b0;
        end else begin
            state <= next_state;
            ptr <= next_ptr;
            active_group <= next_active_group;
            pending <= next_pending;
            fetched_loaded <= next_fetched_loaded;
            fetched_mode <= next_fetched_mode;
            shift_tx_data <= next_shift_tx_data;
            shift_start <= next_shift_start;
        end
    end

    assign seq_busy = (state != spi_seq_pkg::SEQ_IDLE);

    // ----------------------------------------------------------------
    // flags and buffer storage
    // ----------------------------------------------------------------
    // the read path is independent of the fetch path, so a read in the
    // fetch cycle still marks its slot vacant; a store to the same slot
    // in the same cycle wins, since that word is still unread
    always_comb begin
        next_vacant = receive_slot_vacant_flag;
        next_loaded = transmit_slot_loaded_flag;
        next_rx_overrun = 1'b0;
        next_host_rd_data = host_rd_data;
        if (host_rd_valid) begin
            next_vacant[host_rd_index] = 1'b1;
            next_host_rd_data = rx_mem[host_rd_index];
        end
        if (fetch_go) begin
            next_loaded[ptr] = 1'b0;
        end
        if (tx_wr_valid) begin
            next_loaded[tx_wr_index] = 1'b1;
        end
        if (store_go) begin
            next_vacant[ptr] = 1'b0;
            // suspend modes never reach here with unread data
            next_rx_overrun = !is_suspend(fetched_mode) && !receive_slot_vacant_flag[ptr];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            receive_slot_vacant_flag <= {spi_seq_pkg::NUM_BUF{spi_seq_pkg::VACANT_RESET}};
            transmit_slot_loaded_flag <= {spi_seq_pkg::NUM_BUF{spi_seq_pkg::LOADED_RESET}};
            rx_overrun <= 1'b0;
            host_rd_data <= spi_seq_pkg::DATA_RESET;
        end else begin
            receive_slot_vacant_flag <= next_vacant;
            transmit_slot_loaded_flag <= next_loaded;
            rx_overrun <= next_rx_overrun;
            host_rd_data <= next_host_rd_data;
        end
    end

    // buffer words have no reset; only the flags say what is valid
    always_ff @(posedge clk) begin
        for (int i = 0; i < spi_seq_pkg::NUM_BUF; i++) begin
            if (tx_wr_valid && tx_wr_index == spi_seq_pkg::IDX_W'(i)) begin
                tx_mem[i] <= tx_wr_entry;
            end
            if (store_go && ptr == spi_seq_pkg::IDX_W'(i)) begin
                rx_mem[i] <= shift_rx_data;
            end
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    chk_read_sets_vacant: assert property (
        host_rd_valid && !(store_go && ptr == host_rd_index)
        |=> receive_slot_vacant_flag[$past(host_rd_index)])
        else $error("host read did not mark slot vacant");

    chk_read_during_fetch: assert property (
        host_rd_valid && state == spi_seq_pkg::SEQ_FETCH && !store_go
        |=> receive_slot_vacant_flag[$past(host_rd_index)])
        else $error("read during fetch lost its flag update");

    chk_preempt_restart: assert property (
        preempt |=> state == spi_seq_pkg::SEQ_FETCH && active_group == $past(req_group)
        && ptr == group_range[active_group].first)
        else $error("pre-emption did not restart at first buffer");

    chk_loaded_sampled: assert property (
        state == spi_seq_pkg::SEQ_FETCH && !preempt
        |=> fetched_loaded == $past(transmit_slot_loaded_flag[ptr]))
        else $error("loaded flag not sampled with the buffer");

    chk_suspend_stall: assert property (
        state == spi_seq_pkg::SEQ_FETCH && !preempt && is_suspend(tx_mem[ptr].mode)
        && !receive_slot_vacant_flag[ptr] |-> !fetch_go ##1 !shift_start)
        else $error("suspend buffer started over unread data");

    chk_overrun_report: assert property (
        store_go && !is_suspend(fetched_mode) && !receive_slot_vacant_flag[ptr]
        && !host_rd_valid |=> rx_overrun)
        else $error("overrun not reported");

    chk_no_false_overrun: assert property (
        rx_overrun |-> $past(store_go) && $past(!receive_slot_vacant_flag[ptr]))
        else $error("overrun without unread data");

    chk_store_clears_vacant: assert property (
        store_go |=> !receive_slot_vacant_flag[$past(ptr)])
        else $error("stored word not marked unread");

    chk_start_after_fetch: assert property (
        shift_start |-> state == spi_seq_pkg::SEQ_SHIFT && $past(state == spi_seq_pkg::SEQ_FETCH))
        else $error("shift start outside a fetch");

    cov_preempt: cover property (preempt);
    cov_suspend_then_go: cover property (
        state == spi_seq_pkg::SEQ_FETCH && is_suspend(tx_mem[ptr].mode)
        && !receive_slot_vacant_flag[ptr] ##[1:20] shift_start);
    cov_overrun: cover property (rx_overrun);
    cov_read_in_fetch: cover property (host_rd_valid && state == spi_seq_pkg::SEQ_FETCH);

endmodule

// ===== design/spi_seq_pkg.sv
// shared constants and carriers for the buffered spi sequencer
package spi_seq_pkg;

    // ----------------------------------------------------------------
    // sizes
    // ----------------------------------------------------------------
    localparam int NUM_BUF = 8;
    localparam int IDX_W = 3;
    localparam int NUM_GROUPS = 2;
    localparam int GRP_W = 1;
    localparam int DATA_W = 16;
    localparam int MODE_W = 3;

    // ----------------------------------------------------------------
    // buffer handling mode codes
    // ----------------------------------------------------------------
    localparam logic [MODE_W-1:0] MODE_DISABLED = 3'h0;
    localparam logic [MODE_W-1:0] MODE_SKIP_EMPTY = 3'h1;
    localparam logic [MODE_W-1:0] MODE_SUSPEND_A = 3'h6;
    localparam logic [MODE_W-1:0] MODE_SUSPEND_B = 3'h7;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic VACANT_RESET = 1'b1;
    localparam logic LOADED_RESET = 1'b0;
    localparam logic [DATA_W-1:0] DATA_RESET = 16'h0000;

    // one transmit buffer: handling mode and the word to send
    typedef struct packed {
        logic [MODE_W-1:0] mode;
        logic [DATA_W-1:0] data;
    } tx_entry_t;

    // one transfer group: first and last buffer index, inclusive
    typedef struct packed {
        logic [IDX_W-1:0] first;
        logic [IDX_W-1:0] last;
    } group_range_t;

    // sequencer states
    typedef enum logic [2:0] {
        SEQ_IDLE = 3'h1,
        SEQ_FETCH = 3'h2,
        SEQ_SHIFT = 3'h4
    } seq_state_t;

endpackage

// ===== sim/multibuffer_spi_sequencer_flags_bench.sv
// self-checking bench for the buffered spi sequencer and its flags
`timescale 1ns/1ps

module multibuffer_spi_sequencer_flags_bench;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic tx_wr_valid = 1'b0;
    logic [2:0] tx_wr_index = 3'h0;
    spi_seq_pkg::tx_entry_t tx_wr_entry = '0;
    logic host_rd_valid = 1'b0;
    logic [2:0] host_rd_index = 3'h0;
    logic [15:0] host_rd_data;
    spi_seq_pkg::group_range_t group_range [spi_seq_pkg::NUM_GROUPS];
    logic [1:0] group_trigger = 2'h0;
    logic shift_start, shift_done, rx_overrun, seq_busy;
    logic [15:0] shift_tx_data, shift_rx_data, last_tx;
    logic [0:0] active_group;
    logic [7:0] vacant, loaded;
    logic [3:0] delay = 4'h2;
    int err_total = 0;
    int n_tests = 0;
    int n_starts = 0;
    int n_ov = 0;

    // --------------------------------------------------------------
    // clock, design and partner
    // --------------------------------------------------------------
    always #5 clk = ~clk;

    spi_seq_flags dut_u (.clk(clk), .reset_n(reset_n), .tx_wr_valid(tx_wr_valid),
        .tx_wr_index(tx_wr_index), .tx_wr_entry(tx_wr_entry), .host_rd_valid(host_rd_valid),
        .host_rd_index(host_rd_index), .host_rd_data(host_rd_data),
        .group_range(group_range), .group_trigger(group_trigger), .shift_start(shift_start),
        .shift_tx_data(shift_tx_data), .shift_done(shift_done), .shift_rx_data(shift_rx_data),
        .rx_overrun(rx_overrun), .seq_busy(seq_busy), .active_group(active_group),
        .receive_slot_vacant_flag(vacant), .transmit_slot_loaded_flag(loaded));

    shift_engine_model engine_u (.clk(clk), .reset_n(reset_n), .delay(delay),
        .shift_start(shift_start), .shift_tx_data(shift_tx_data),
        .shift_done(shift_done), .shift_rx_data(shift_rx_data));

    // one-cycle pulses are counted at the edge that samples them
    always @(posedge clk) begin
        if (shift_start === 1'b1) begin
            n_starts++;
            last_tx = shift_tx_data;
        end
        if (rx_overrun === 1'b1) n_ov++;
    end

    // --------------------------------------------------------------
    // shared tasks
    // --------------------------------------------------------------
    task automatic print_verdict();
        if (err_total == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic write_tx(input logic [2:0] idx, input logic [2:0] mode, input logic [15:0] d);
        @(posedge clk);
        tx_wr_valid <= 1'b1;
        tx_wr_index <= idx;
        tx_wr_entry <= '{mode: mode, data: d};
        @(posedge clk);
        tx_wr_valid <= 1'b0;
        #1;
    endtask

    // read data lands on the taking edge, so look just after it
    task automatic read_rx(input logic [2:0] idx, input logic [15:0] exp);
        @(posedge clk);
        host_rd_valid <= 1'b1;
        host_rd_index <= idx;
        @(posedge clk);
        host_rd_valid <= 1'b0;
        #1 check("host_rd_data", 32'(exp), 32'(host_rd_data));
    endtask

    task automatic trigger(input int g);
        @(posedge clk);
        group_trigger <= 2'(1 << g);
        @(posedge clk);
        group_trigger <= 2'h0;
    endtask

    // bounded wait; a hang ends the run through the verdict
    task automatic wait_idle();
        int i;
        repeat (3) @(posedge clk);
        for (i = 0; i < 300 && seq_busy !== 1'b0; i++) @(posedge clk);
        if (seq_busy !== 1'b0) begin
            err_total++;
            $display("mismatch seq_busy expected 0 seen %b", seq_busy);
            print_verdict();
        end
        #1;
    endtask

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    task automatic sc_basic();
        int s0;
        s0 = n_starts;
        check("vacant reset", 32'hFF, 32'(vacant));
        check("loaded reset", 32'h00, 32'(loaded));
        write_tx(3'h4, 3'h2, 16'h1234);
        write_tx(3'h5, 3'h3, 16'hA55A);
        check("loaded", 32'h30, 32'(loaded));
        group_range[1] <= '{first: 3'h4, last: 3'h5};
        trigger(1);
        wait_idle();
        check("starts", 32'h2, 32'(n_starts - s0));
        check("vacant", 32'hCF, 32'(vacant));
        check("overruns", 32'h0, 32'(n_ov));
        read_rx(3'h4, 16'hEDCB);
        check("vacant", 32'hDF, 32'(vacant));
    endtask

    task automatic sc_overrun();
        delay <= 4'h9; // slow partner answer
        write_tx(3'h4, 3'h2, 16'h00FF);
        write_tx(3'h5, 3'h4, 16'h0F0F);
        trigger(1);
        wait_idle();
        check("overruns", 32'h1, 32'(n_ov));
        read_rx(3'h5, 16'hF0F0);
        check("vacant", 32'hEF, 32'(vacant));
    endtask

    task automatic sc_suspend();
        int s0;
        delay <= 4'h2;
        group_range[0] <= '{first: 3'h2, last: 3'h2};
        write_tx(3'h2, spi_seq_pkg::MODE_SUSPEND_A, 16'h2222);
        trigger(0);
        wait_idle();
        check("vacant", 32'hEB, 32'(vacant));
        write_tx(3'h2, spi_seq_pkg::MODE_SUSPEND_B, 16'h3333);
        s0 = n_starts;
        trigger(0);
        repeat (20) @(posedge clk);
        #1 check("busy stalled", 32'h1, 32'(seq_busy));
        check("stalled starts", 32'h0, 32'(n_starts - s0));
        read_rx(3'h2, 16'hDDDD);
        wait_idle();
        check("starts", 32'h1, 32'(n_starts - s0));
        check("overruns", 32'h1, 32'(n_ov));
    endtask

    // group 0 pre-empts group 1 while the host reads a filled slot
    task automatic sc_preempt();
        int s0;
        read_rx(3'h2, 16'hCCCC);
        write_tx(3'h2, spi_seq_pkg::MODE_SUSPEND_A, 16'h4444);
        write_tx(3'h3, spi_seq_pkg::MODE_DISABLED, 16'h0003);
        write_tx(3'h4, spi_seq_pkg::MODE_DISABLED, 16'h0004);
        write_tx(3'h5, spi_seq_pkg::MODE_DISABLED, 16'h0005);
        write_tx(3'h6, 3'h2, 16'h6666);
        group_range[1] <= '{first: 3'h3, last: 3'h6};
        s0 = n_starts;
        @(posedge clk);
        group_trigger <= 2'h2;
        @(posedge clk);
        group_trigger <= 2'h1;
        @(posedge clk);
        group_trigger <= 2'h0;
        host_rd_valid <= 1'b1;
        host_rd_index <= 3'h4;
        @(posedge clk);
        host_rd_valid <= 1'b0;
        #1 check("host_rd_data", 32'hFF00, 32'(host_rd_data));
        wait_idle();
        check("vacant", 32'hFB, 32'(vacant));
        check("starts", 32'h1, 32'(n_starts - s0));
        check("last_tx", 32'h4444, 32'(last_tx));
        check("active_group", 32'h0, 32'(active_group));
        check("loaded", 32'h78, 32'(loaded));
        check("overruns", 32'h1, 32'(n_ov));
    endtask

    // disabled buffers never start; skip-when-empty starts only while loaded
    task automatic sc_skip();
        int s0;
        write_tx(3'h4, spi_seq_pkg::MODE_SKIP_EMPTY, 16'h4A4A);
        group_range[1] <= '{first: 3'h3, last: 3'h6};
        s0 = n_starts;
        trigger(1);
        wait_idle();
        check("starts", 32'h2, 32'(n_starts - s0));
        check("last_tx", 32'h6666, 32'(last_tx));
        check("loaded", 32'h28, 32'(loaded));
        check("vacant", 32'hAB, 32'(vacant));
        // second pass: slot 4 is now unloaded and skipped, slot 6 still sends
        s0 = n_starts;
        trigger(1);
        wait_idle();
        check("starts", 32'h1, 32'(n_starts - s0));
        check("overruns", 32'h2, 32'(n_ov));
        read_rx(3'h6, 16'h9999);
        check("vacant", 32'hEB, 32'(vacant));
    endtask

    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        group_range[0] = '{first: 3'h0, last: 3'h0};
        group_range[1] = '{first: 3'h0, last: 3'h0};
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        #1;
        sc_basic();
        sc_overrun();
        sc_suspend();
        sc_preempt();
        sc_skip();
        print_verdict();
    end
endmodule

// ===== sim/shift_engine_model.sv
// behavioural shift engine standing at the far side of the sequencer
`timescale 1ns/1ps

module shift_engine_model (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [3:0] delay,
    input wire logic shift_start,
    input wire logic [spi_seq_pkg::DATA_W-1:0] shift_tx_data,
    output logic shift_done,
    output logic [spi_seq_pkg::DATA_W-1:0] shift_rx_data
);
    int cnt;

    // --------------------------------------------------------------
    // word timing: answers delay+1 cycles after each start
    // --------------------------------------------------------------
    // the echoed word is inverted so a stale or looped-back word shows
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt <= 0;
            shift_done <= 1'b0;
            shift_rx_data <= 16'h0000;
        end else begin
            shift_done <= 1'b0;
            shift_rx_data <= ~shift_rx_data; // line not valid between words
            if (shift_start) begin
                cnt <= int'(delay) + 1;
            end else if (cnt == 1) begin
                shift_done <= 1'b1;
                shift_rx_data <= ~shift_tx_data;
                cnt <= 0;
            end else if (cnt > 1) begin
                cnt <= cnt - 1;
            end
        end
    end
endmodule
